// [hdl/ebu_pkg.sv]
// Shared constants and types of the external bus unit.
package ebu_pkg;
   // -------------------------------------------------------------------------
   // Address spaces
   // -------------------------------------------------------------------------
   localparam int NUM_BLOCKS = 6;
   localparam int NUM_SPACES = 7;
   localparam logic [2:0] OTHER_SPACE = 3'h6;
   localparam int NUM_BUS_PORTS = 5;
   localparam int PORT0 = 0;
   localparam int PORT1 = 1;
   localparam int PORT2 = 2;
   localparam int PORT5 = 3;
   localparam int PORT6 = 4;
   // -------------------------------------------------------------------------
   // Access sizes and multiplexed pin arrangements
   // -------------------------------------------------------------------------
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] ARR_A24_D8 = 2'h0;
   localparam logic [1:0] ARR_A24_D16 = 2'h1;
   localparam logic [1:0] ARR_A16_D8 = 2'h2;
   localparam logic [1:0] ARR_A8_D16 = 2'h3;
   // -------------------------------------------------------------------------
   // Timing counts in system clocks
   // -------------------------------------------------------------------------
   localparam int BASIC_CYCLE_CLOCKS = 3;
   localparam int MAX_AUTO_WAIT = 7;
   localparam int MAX_RECOVERY = 2;
   localparam int MAX_CS_RECOVERY = 1;
   localparam logic [2:0] EXT_WAIT_LOAD = 3'h1;
   // -------------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------------
   localparam logic [7:0] PIN_RESET = 8'h00;
   localparam logic [5:0] CS_IDLE_N = 6'h3F;
   localparam logic [1:0] LANE_IDLE_N = 2'h3;
   typedef enum logic [3:0] {
      ST_IDLE, ST_HOLD, ST_INTERNAL, ST_CSRCV, ST_ADDR,
      ST_STROBE, ST_WAIT, ST_LAST, ST_RECOV
   } ebu_state_t;
endpackage

// [hdl/ebu_csdec.sv]
// Chip-select decoder mapping an address onto six blocks or the other space.
`timescale 1ns/100ps
`default_nettype none
module ebu_csdec import ebu_pkg::*; (
   // Address and block windows
   input wire logic [31:0] i_addr,
   input wire logic [NUM_BLOCKS-1:0][15:0] i_base,
   input wire logic [NUM_BLOCKS-1:0][15:0] i_mask,
   input wire logic [NUM_BLOCKS-1:0] i_enable,
   // Selected space
   output logic [2:0] o_space
);
   logic [NUM_BLOCKS-1:0] hit;

   function automatic logic blk_hit(input logic [15:0] a, input logic [15:0] b,
                                    input logic [15:0] m);
      blk_hit = ((a ^ b) & ~m) == 16'h0000;
   endfunction

   // -------------------------------------------------------------------------
   // Window compare, lowest block wins
   // -------------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_BLOCKS; g++) begin : g_hit
         assign hit[g] = i_enable[g] && blk_hit(i_addr[31:16], i_base[g], i_mask[g]);
      end
   endgenerate

   always_comb begin
      o_space = OTHER_SPACE;
      for (int i = NUM_BLOCKS - 1; i >= 0; i--) begin
         if (hit[i]) begin
            o_space = 3'(i);
         end
      end
   end
endmodule
`default_nettype wire

// [hdl/ebu_lane.sv]
// Byte-lane steering for one bus piece of a split access.
`timescale 1ns/100ps
`default_nettype none
module ebu_lane import ebu_pkg::*; (
   // Access description
   input wire logic i_big,
   input wire logic i_wide,
   input wire logic [1:0] i_size,
   input wire logic [1:0] i_addr_lo,
   input wire logic [1:0] i_piece,
   // Piece layout
   output logic [1:0] o_off,
   output logic [1:0] o_lane_lo,
   output logic [1:0] o_lane_hi,
   output logic [1:0] o_last,
   output logic [1:0] o_byte_en
);
   logic [1:0] mask;

   function automatic logic [1:0] lane_of(input logic [1:0] a, input logic big);
      lane_of = big ? ~a : a;
   endfunction

   // -------------------------------------------------------------------------
   // Piece address and lanes
   // -------------------------------------------------------------------------
   always_comb begin
      mask = (i_size == SIZE_WORD) ? 2'h3 : (i_size == SIZE_HALF) ? 2'h1 : 2'h0;
      if (i_wide) begin
         mask = mask | 2'h1;
      end
      o_off = i_wide ? (i_addr_lo & ~mask) + {i_piece[0], 1'b0} : (i_addr_lo & ~mask) + i_piece;
      o_last = 2'h0;
      if (i_size == SIZE_WORD) begin
         o_last = i_wide ? 2'h1 : 2'h3;
      end else if (i_size == SIZE_HALF && !i_wide) begin
         o_last = 2'h1;
      end
      if (i_wide) begin
         o_lane_lo = lane_of(i_big ? o_off | 2'h1 : o_off, i_big);
         o_lane_hi = lane_of(i_big ? o_off : o_off | 2'h1, i_big);
         o_byte_en = 2'h3;
         if (i_size == SIZE_BYTE) begin
            o_byte_en = (i_addr_lo[0] ^ i_big) ? 2'h2 : 2'h1;
         end
      end else begin
         o_lane_lo = lane_of(o_off, i_big);
         o_lane_hi = o_lane_lo;
         o_byte_en = 2'h1;
      end
   end
endmodule
`default_nettype wire

// [hdl/ebu_main.sv]
// External bus unit: bus cycles, chip selects, waits, sizing and arbitration.
`timescale 1ns/100ps
`default_nettype none
module ebu_main import ebu_pkg::*; (
   // Clock and reset
   input wire logic I_CLOCK,
   input wire logic I_NRST,
   input wire logic I_BUS_MODE_SELECT_PIN,
   // Internal request
   input wire logic I_REQ,
   input wire logic I_REQ_WRITE,
   input wire logic I_REQ_INTERNAL,
   input wire logic [1:0] I_REQ_SIZE,
   input wire logic [31:0] I_REQ_ADDR,
   input wire logic [31:0] I_REQ_WDATA,
   output logic O_BUSY,
   output logic O_DONE,
   output logic [31:0] O_RDATA,
   // Configuration
   input wire logic I_BIG_ENDIAN,
   input wire logic I_READY_SEL,
   input wire logic [1:0] I_MUX_ARRANGE,
   input wire logic [NUM_BUS_PORTS-1:0] I_PORT_DIRECTION_REG,
   input wire logic [NUM_BUS_PORTS-1:0] I_PORT_FUNCTION_SEL_REG,
   input wire logic [NUM_BLOCKS-1:0] I_BLK_ENABLE,
   input wire logic [NUM_BLOCKS-1:0][15:0] I_BLK_BASE,
   input wire logic [NUM_BLOCKS-1:0][15:0] I_BLK_MASK,
   input wire logic [NUM_SPACES-1:0][2:0] I_AUTO_WAIT,
   input wire logic [NUM_SPACES-1:0] I_EXT_WAIT_EN,
   input wire logic [NUM_SPACES-1:0] I_BUS_WIDTH16,
   input wire logic [NUM_SPACES-1:0][1:0] I_RECOVERY,
   input wire logic [NUM_SPACES-1:0] I_CS_RECOVERY_EN,
   output logic O_MUX_MODE,
   // Bus arbitration
   input wire logic I_EXT_BUS_REQ,
   output logic O_EXT_BUS_GRANT,
   // Bus control pins
   input wire logic I_WAIT_RDY_PIN,
   output logic O_ALE,
   output logic O_RD_N,
   output logic O_WR_N,
   output logic [NUM_BLOCKS-1:0] O_CS_N,
   output logic [1:0] O_BYTE_EN_N,
   // Port pins
   input wire logic [7:0] I_P0_IN,
   input wire logic [7:0] I_P1_IN,
   output logic [7:0] O_P0_OUT,
   output logic [7:0] O_P0_OE,
   output logic [7:0] O_P1_OUT,
   output logic [7:0] O_P1_OE,
   output logic [7:0] O_P2_OUT,
   output logic [7:0] O_P2_OE,
   output logic [7:0] O_P5_OUT,
   output logic [7:0] O_P5_OE,
   output logic [7:0] O_P6_OUT,
   output logic [7:0] O_P6_OE
);
   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   logic [1:0] rst_pipe;
   logic rst_n;
   logic mode_taken;
   logic mux_mode;
   ebu_state_t state;
   ebu_state_t next_state;
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic take;
   logic finish;
   logic req_write;
   logic [1:0] req_size;
   logic [31:0] req_addr;
   logic [31:0] req_wdata;
   logic [2:0] req_space;
   logic [2:0] last_space;
   logic have_last;
   logic [1:0] piece;
   logic [1:0] next_piece;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic [31:0] sel_addr;
   logic [1:0] sel_size;
   logic [2:0] dec_space;
   logic [2:0] sel_space;
   logic data16;
   logic arr_d16;
   logic ext_hold;
   logic cs_rcv_need;
   logic more;
   logic strobe_phase;
   logic [NUM_BUS_PORTS-1:0] port_en;
   logic [31:0] cur_addr;
   logic [1:0] cur_off;
   logic [1:0] cur_lo;
   logic [1:0] cur_hi;
   logic [1:0] cur_last;
   logic [1:0] nxt_off;
   logic [1:0] nxt_lo;
   logic [1:0] nxt_hi;
   logic [1:0] nxt_be;

   // -------------------------------------------------------------------------
   // Reset release and bus mode strap
   // -------------------------------------------------------------------------
   always_ff @(posedge I_CLOCK or negedge I_NRST) begin
      if (!I_NRST) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         mode_taken <= 1'b0;
         mux_mode <= 1'b0;
      end else if (!mode_taken) begin
         mode_taken <= 1'b1;
         mux_mode <= I_BUS_MODE_SELECT_PIN;
      end
   end

   // -------------------------------------------------------------------------
   // Space decode and piece layout
   // -------------------------------------------------------------------------
   assign sel_addr = (state == ST_IDLE) ? I_REQ_ADDR : req_addr;
   assign sel_size = (state == ST_IDLE) ? I_REQ_SIZE : req_size;
   assign sel_space = (state == ST_IDLE) ? dec_space : req_space;
   assign arr_d16 = (I_MUX_ARRANGE == ARR_A24_D16) || (I_MUX_ARRANGE == ARR_A8_D16);
   assign data16 = I_BUS_WIDTH16[sel_space] && (!mux_mode || arr_d16);
   assign port_en = I_PORT_DIRECTION_REG & I_PORT_FUNCTION_SEL_REG;
   assign ext_hold = I_EXT_WAIT_EN[sel_space] && (I_READY_SEL ? I_WAIT_RDY_PIN
                                                              : !I_WAIT_RDY_PIN);
   assign cs_rcv_need = have_last && (dec_space != last_space) && I_CS_RECOVERY_EN[last_space];
   assign more = piece != cur_last;
   assign cur_addr = {sel_addr[31:2], nxt_off};
   assign strobe_phase = (next_state == ST_STROBE) || (next_state == ST_WAIT) ||
                         (next_state == ST_LAST);

   ebu_csdec u_csdec (
      .i_addr(sel_addr),
      .i_base(I_BLK_BASE),
      .i_mask(I_BLK_MASK),
      .i_enable(I_BLK_ENABLE),
      .o_space(dec_space)
   );

   ebu_lane u_lane_cur (
      .i_big(I_BIG_ENDIAN),
      .i_wide(data16),
      .i_size(sel_size),
      .i_addr_lo(sel_addr[1:0]),
      .i_piece(piece),
      .o_off(cur_off),
      .o_lane_lo(cur_lo),
      .o_lane_hi(cur_hi),
      .o_last(cur_last),
      .o_byte_en()
   );

   ebu_lane u_lane_nxt (
      .i_big(I_BIG_ENDIAN),
      .i_wide(data16),
      .i_size(sel_size),
      .i_addr_lo(sel_addr[1:0]),
      .i_piece(next_piece),
      .o_off(nxt_off),
      .o_lane_lo(nxt_lo),
      .o_lane_hi(nxt_hi),
      .o_last(),
      .o_byte_en(nxt_be)
   );

   // -------------------------------------------------------------------------
   // Cycle sequencer
   // -------------------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      take = 1'b0;
      finish = 1'b0;
      unique case (state)
         ST_IDLE: begin
            if (mode_taken && I_EXT_BUS_REQ) begin
               next_state = ST_HOLD;
            end else if (mode_taken && I_REQ) begin
               take = 1'b1;
               if (I_REQ_INTERNAL) begin
                  next_state = ST_INTERNAL;
               end else if (cs_rcv_need) begin
                  next_state = ST_CSRCV;
               end else begin
                  next_state = ST_ADDR;
               end
            end
         end
         ST_HOLD: begin
            if (!I_EXT_BUS_REQ) begin
               next_state = ST_IDLE;
            end
         end
         ST_INTERNAL: begin
            finish = 1'b1;
            next_state = ST_IDLE;
         end
         ST_CSRCV: next_state = ST_ADDR;
         ST_ADDR: next_state = ST_STROBE;
         ST_STROBE: begin
            if (I_AUTO_WAIT[sel_space] != 3'h0) begin
               next_state = ST_WAIT;
               next_cnt = I_AUTO_WAIT[sel_space] - 3'h1;
            end else if (ext_hold) begin
               next_state = ST_WAIT;
               next_cnt = EXT_WAIT_LOAD;
            end else begin
               next_state = ST_LAST;
            end
         end
         ST_WAIT: begin
            if (cnt != 3'h0) begin
               next_cnt = cnt - 3'h1;
            end else if (ext_hold) begin
               next_cnt = EXT_WAIT_LOAD;
            end else begin
               next_state = ST_LAST;
            end
         end
         ST_LAST: begin
            if (I_RECOVERY[sel_space] != 2'h0) begin
               next_state = ST_RECOV;
               next_cnt = {1'b0, I_RECOVERY[sel_space]} - 3'h1;
            end else if (more) begin
               next_state = ST_ADDR;
            end else begin
               next_state = ST_IDLE;
               finish = 1'b1;
            end
         end
         ST_RECOV: begin
            if (cnt != 3'h0) begin
               next_cnt = cnt - 3'h1;
            end else if (more) begin
               next_state = ST_ADDR;
            end else begin
               next_state = ST_IDLE;
               finish = 1'b1;
            end
         end
      endcase
   end

   always_comb begin
      next_piece = piece;
      if (take || finish) begin
         next_piece = 2'h0;
      end else if (next_state == ST_ADDR && (state == ST_LAST || state == ST_RECOV)) begin
         next_piece = piece + 2'h1;
      end
   end

   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         cnt <= 3'h0;
         piece <= 2'h0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         piece <= next_piece;
      end
   end

   // -------------------------------------------------------------------------
   // Request latch
   // -------------------------------------------------------------------------
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         req_write <= 1'b0;
         req_size <= SIZE_BYTE;
         req_addr <= 32'h00000000;
         req_wdata <= 32'h00000000;
         req_space <= OTHER_SPACE;
         last_space <= OTHER_SPACE;
         have_last <= 1'b0;
      end else if (take) begin
         req_write <= I_REQ_WRITE;
         req_size <= I_REQ_SIZE;
         req_addr <= I_REQ_ADDR;
         req_wdata <= I_REQ_WDATA;
         req_space <= dec_space;
         if (!I_REQ_INTERNAL) begin
            last_space <= dec_space;
            have_last <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Read assembly
   // -------------------------------------------------------------------------
   always_comb begin
      next_rdata = take ? 32'h00000000 : rdata;
      if (state == ST_LAST && !req_write) begin
         next_rdata[{cur_lo, 3'h0} +: 8] = I_P0_IN;
         if (data16) begin
            next_rdata[{cur_hi, 3'h0} +: 8] = I_P1_IN;
         end
      end
   end

   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h00000000;
         O_RDATA <= 32'h00000000;
         O_DONE <= 1'b0;
         O_BUSY <= 1'b0;
         O_MUX_MODE <= 1'b0;
      end else begin
         rdata <= next_rdata;
         if (finish) begin
            O_RDATA <= next_rdata;
         end
         O_DONE <= finish;
         O_BUSY <= next_state != ST_IDLE;
         O_MUX_MODE <= mux_mode;
      end
   end

   // -------------------------------------------------------------------------
   // Control strobes
   // -------------------------------------------------------------------------
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         O_ALE <= 1'b0;
         O_RD_N <= 1'b1;
         O_WR_N <= 1'b1;
         O_CS_N <= CS_IDLE_N;
         O_BYTE_EN_N <= LANE_IDLE_N;
         O_EXT_BUS_GRANT <= 1'b0;
      end else begin
         O_ALE <= mux_mode && (next_state == ST_ADDR);
         O_RD_N <= !(strobe_phase && !req_write);
         O_WR_N <= !(strobe_phase && req_write);
         O_CS_N <= CS_IDLE_N;
         if (strobe_phase || next_state == ST_ADDR) begin
            for (int i = 0; i < NUM_BLOCKS; i++) begin
               O_CS_N[i] <= sel_space != 3'(i);
            end
         end
         O_BYTE_EN_N <= (strobe_phase || next_state == ST_ADDR) ? ~nxt_be : LANE_IDLE_N;
         O_EXT_BUS_GRANT <= next_state == ST_HOLD;
      end
   end

   // -------------------------------------------------------------------------
   // Address and data pins
   // -------------------------------------------------------------------------
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         O_P0_OUT <= PIN_RESET;
         O_P0_OE <= PIN_RESET;
         O_P1_OUT <= PIN_RESET;
         O_P1_OE <= PIN_RESET;
         O_P2_OUT <= PIN_RESET;
         O_P2_OE <= PIN_RESET;
         O_P5_OUT <= PIN_RESET;
         O_P5_OE <= PIN_RESET;
         O_P6_OUT <= PIN_RESET;
         O_P6_OE <= PIN_RESET;
      end else if (next_state == ST_HOLD) begin
         O_P0_OE <= PIN_RESET;
         O_P1_OE <= PIN_RESET;
         O_P2_OE <= PIN_RESET;
         O_P5_OE <= PIN_RESET;
         O_P6_OE <= PIN_RESET;
      end else if (next_state == ST_ADDR && !mux_mode) begin
         O_P5_OUT <= cur_addr[7:0];
         O_P6_OUT <= cur_addr[15:8];
         O_P2_OUT <= cur_addr[23:16];
         O_P5_OE <= {8{port_en[PORT5]}};
         O_P6_OE <= {8{port_en[PORT6]}};
         O_P2_OE <= {8{port_en[PORT2]}};
         O_P0_OE <= PIN_RESET;
         O_P1_OE <= PIN_RESET;
      end else if (next_state == ST_ADDR) begin
         O_P0_OUT <= cur_addr[7:0];
         O_P0_OE <= {8{port_en[PORT0]}};
         O_P1_OUT <= cur_addr[15:8];
         O_P1_OE <= {8{port_en[PORT1]}};
         if (I_MUX_ARRANGE == ARR_A24_D8 || I_MUX_ARRANGE == ARR_A24_D16) begin
            O_P2_OUT <= cur_addr[23:16];
         end else begin
            O_P2_OUT <= cur_addr[7:0];
         end
         O_P2_OE <= {8{port_en[PORT2]}};
         O_P5_OE <= PIN_RESET;
         O_P6_OE <= PIN_RESET;
      end else if (strobe_phase) begin
         O_P0_OUT <= req_wdata[{nxt_lo, 3'h0} +: 8];
         O_P0_OE <= {8{port_en[PORT0] && req_write}};
         if (data16) begin
            O_P1_OUT <= req_wdata[{nxt_hi, 3'h0} +: 8];
            O_P1_OE <= {8{port_en[PORT1] && req_write}};
         end else if (!mux_mode) begin
            O_P1_OE <= PIN_RESET;
         end
      end else begin
         O_P0_OE <= PIN_RESET;
         if (!mux_mode || arr_d16) begin
            O_P1_OE <= PIN_RESET;
         end
      end
   end
   // Address-only pins keep their last value outside ADDR and HOLD, so internal
   // accesses never disturb them.
endmodule
`default_nettype wire

// [tb/ebu_sva.sv]
// Checker for the external bus unit ports.
`timescale 1ns/100ps
`default_nettype none
module ebu_sva import ebu_pkg::*; (
   input wire logic I_CLOCK, I_NRST, I_EXT_BUS_REQ, O_EXT_BUS_GRANT,
   input wire logic O_MUX_MODE, O_ALE, O_RD_N, O_WR_N,
   input wire logic [7:0] O_P0_OE, O_P1_OE, O_P5_OE, O_P6_OE
);
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_NRST);
   sequence strobe_on; !O_RD_N || !O_WR_N; endsequence
   sequence rd_hold; !O_RD_N [*2]; endsequence
   rw_excl_a: assert property (!(!O_RD_N && !O_WR_N)) else $error("two strobes");
   rd_len_a: assert property ($fell(O_RD_N) |-> rd_hold) else $error("short read");
   rd_hiz_a: assert property (!O_RD_N |-> (O_P0_OE | (O_MUX_MODE ? 8'h00 : O_P1_OE)) == 8'h00)
      else $error("data driven in read");
   ale_lead_a: assert property (O_ALE |=> strobe_on) else $error("no strobe");
   sep_ale_a: assert property (!O_MUX_MODE |-> !O_ALE) else $error("latch pulse");
   mux_free_a: assert property (O_MUX_MODE |-> (O_P5_OE | O_P6_OE) == 8'h00)
      else $error("port 5 or 6 driven");
   grant_oe_a: assert property (O_EXT_BUS_GRANT |-> (O_P0_OE | O_P5_OE) == 8'h00)
      else $error("driven in grant");
   grant_req_a: assert property ($rose(O_EXT_BUS_GRANT) |-> $past(I_EXT_BUS_REQ))
      else $error("grant without request");
endmodule
bind ebu_main ebu_sva i_ebu_sva (.*);
`default_nettype wire

// [tb/ebu_mem.sv]
// Memory model on the far side of the external bus.
`timescale 1ns/100ps
`default_nettype none
module ebu_mem (
   input wire logic i_clock, i_slow, i_ready_sel, i_rd_n, i_wr_n,
   input wire logic [1:0] i_be_n,
   input wire logic [7:0] i_addr, i_p0, i_p0_oe, i_p1, i_p1_oe,
   output logic [7:0] o_p0, o_p1,
   output logic o_wait_pin
);
   logic [7:0] lo [256];
   logic [7:0] hi [256];
   logic [15:0] last = 16'h0000;
   int cnt = 0;
   always @(posedge i_clock) begin
      if (!i_wr_n && !i_be_n[0]) lo[i_addr] <= i_p0;
      if (!i_wr_n && !i_be_n[1]) hi[i_addr] <= i_p1;
      if (!i_rd_n) last <= {hi[i_addr], lo[i_addr]};
      cnt <= (i_rd_n && i_wr_n) ? 0 : cnt + 1;
   end
   // Released data lines show the addressed memory during a read, else the inverse of the last value read.
   assign o_p0 = i_p0_oe & i_p0 | ~i_p0_oe & (i_rd_n ? ~last[7:0] : lo[i_addr]);
   assign o_p1 = i_p1_oe & i_p1 | ~i_p1_oe & (i_rd_n ? ~last[15:8] : hi[i_addr]);
   assign o_wait_pin = i_ready_sel ^ !(i_slow && !(i_rd_n && i_wr_n) && cnt < 3);
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Testbench for the external bus unit.
`timescale 1ns/100ps
`default_nettype none
module tb_top import ebu_pkg::*;;
   logic I_CLOCK, I_NRST, I_BUS_MODE_SELECT_PIN, I_REQ, I_REQ_WRITE, I_REQ_INTERNAL;
   logic I_BIG_ENDIAN, I_READY_SEL, I_EXT_BUS_REQ, I_WAIT_RDY_PIN, O_BUSY, O_DONE;
   logic O_MUX_MODE, O_EXT_BUS_GRANT, O_ALE, O_RD_N, O_WR_N, slow;
   logic [1:0] I_REQ_SIZE, I_MUX_ARRANGE, O_BYTE_EN_N;
   logic [31:0] I_REQ_ADDR, I_REQ_WDATA, O_RDATA;
   logic [4:0] I_PORT_DIRECTION_REG, I_PORT_FUNCTION_SEL_REG;
   logic [5:0] I_BLK_ENABLE, O_CS_N;
   logic [5:0][15:0] I_BLK_BASE, I_BLK_MASK;
   logic [6:0][2:0] I_AUTO_WAIT;
   logic [6:0][1:0] I_RECOVERY;
   logic [6:0] I_EXT_WAIT_EN, I_BUS_WIDTH16, I_CS_RECOVERY_EN;
   logic [7:0] I_P0_IN, I_P1_IN, O_P0_OUT, O_P0_OE, O_P1_OUT, O_P1_OE, O_P2_OUT, O_P2_OE;
   logic [7:0] O_P5_OUT, O_P5_OE, O_P6_OUT, O_P6_OE;
   int n_errors = 0;
   int samples_checked = 0;
   int lat;
   ebu_main i_ebu_main (.*);
   ebu_mem i_ebu_mem (.i_clock(I_CLOCK), .i_slow(slow), .i_ready_sel(I_READY_SEL),
      .i_rd_n(O_RD_N), .i_wr_n(O_WR_N), .i_be_n(O_BYTE_EN_N), .i_addr(O_P5_OUT),
      .i_p0(O_P0_OUT), .i_p0_oe(O_P0_OE), .i_p1(O_P1_OUT), .i_p1_oe(O_P1_OE),
      .o_p0(I_P0_IN), .o_p1(I_P1_IN), .o_wait_pin(I_WAIT_RDY_PIN));
   initial begin
      I_CLOCK = 1'b0;
      forever #5 I_CLOCK = ~I_CLOCK;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic access(input logic wr, intl, input logic [31:0] adr, wd);
      int k;
      I_REQ = 1'b1;
      I_REQ_WRITE = wr;
      I_REQ_INTERNAL = intl;
      I_REQ_ADDR = adr;
      I_REQ_WDATA = wd;
      lat = 0;
      k = 0;
      do begin
         @(negedge I_CLOCK);
         lat++;
         k++;
         if (O_BUSY === 1'b1 || O_DONE === 1'b1)
            I_REQ = 1'b0;
      end while (k < 99 && O_DONE !== 1'b1);
      if (O_DONE !== 1'b1) begin
         n_errors++;
         end_of_test();
      end
   endtask
   task automatic do_reset(input logic mode);
      I_NRST = 1'b0;
      I_BUS_MODE_SELECT_PIN = mode;
      I_PORT_DIRECTION_REG = 5'h00;
      I_PORT_FUNCTION_SEL_REG = 5'h00;
      repeat (12) @(negedge I_CLOCK);
      I_NRST = 1'b1;
      repeat (5) @(negedge I_CLOCK);
      check(O_MUX_MODE, mode);
      check(O_P0_OE | O_P1_OE | O_P2_OE | O_P5_OE | O_P6_OE, 8'h00);
      I_PORT_DIRECTION_REG = 5'h1F;
      I_PORT_FUNCTION_SEL_REG = 5'h1F;
      access(1'b0, 1'b0, 32'h0001_0000, 32'h0);
      check(lat, 4);
      check(O_P2_OUT, 8'h01);
      $display("reset test done");
   endtask
   task automatic t_basic();
      I_REQ_SIZE = SIZE_HALF;
      access(1'b1, 1'b0, 32'h0001_0010, 32'h0000_A55A);
      check(lat, 4);
      access(1'b0, 1'b0, 32'h0001_0010, 32'h0);
      check(O_RDATA[15:0], 16'hA55A);
      check({O_P2_OUT, O_P6_OUT, O_P5_OUT}, 24'h01_0010);
      access(1'b0, 1'b1, 32'h0000_0040, 32'h0);
      check(lat, 2);
      check({O_P2_OUT, O_P6_OUT, O_P5_OUT}, 24'h01_0010);
      check(O_RDATA, 32'h0);
      $display("basic test done");
   endtask
   task automatic t_waits();
      for (int w = 0; w < 8; w++) begin
         I_AUTO_WAIT[0] = 3'(w);
         I_RECOVERY[0] = 2'(w % 3);
         access(1'b0, 1'b0, 32'h0001_0010, 32'h0);
         check(lat, 4 + w + w % 3);
      end
      I_AUTO_WAIT = '0;
      I_RECOVERY = '0;
      I_CS_RECOVERY_EN = 7'h7F;
      access(1'b0, 1'b0, 32'h0050_0000, 32'h0);
      check(lat, 5);
      I_CS_RECOVERY_EN = 7'h00;
      $display("wait test done");
   endtask
   task automatic t_split();
      I_REQ_SIZE = SIZE_WORD;
      for (int i = 0; i < 4; i++) begin
         I_BUS_WIDTH16[0] = i[1];
         I_BIG_ENDIAN = i[0];
         access(1'b1, 1'b0, 32'h0001_0020, 32'h1122_3344);
         check(lat, i[1] ? 7 : 13);
         check(O_P5_OUT, i[1] ? 8'h22 : 8'h23);
         access(1'b0, 1'b0, 32'h0001_0020, 32'h0);
         check(O_RDATA, 32'h1122_3344);
      end
      $display("split test done");
   endtask
   task automatic t_ext_wait();
      I_REQ_SIZE = SIZE_HALF;
      I_BIG_ENDIAN = 1'b0;
      I_EXT_WAIT_EN[0] = 1'b1;
      slow = 1'b1;
      for (int r = 0; r < 2; r++) begin
         I_READY_SEL = r[0];
         access(1'b0, 1'b0, 32'h0001_0010, 32'h0);
         check(lat >= 6, 1'b1);
         check(O_RDATA[15:0], 16'hA55A);
      end
      slow = 1'b0;
      $display("external wait test done");
   endtask
   task automatic t_grant();
      I_EXT_BUS_REQ = 1'b1;
      repeat (2) @(negedge I_CLOCK);
      check(O_EXT_BUS_GRANT, 1'b1);
      check(O_P0_OE | O_P5_OE, 8'h00);
      I_EXT_BUS_REQ = 1'b0;
      repeat (2) @(negedge I_CLOCK);
      check(O_EXT_BUS_GRANT, 1'b0);
      $display("grant test done");
   endtask
   initial begin
      {I_REQ, I_REQ_WRITE, I_REQ_INTERNAL, I_BIG_ENDIAN, I_READY_SEL, slow} = 6'h00;
      {I_REQ_SIZE, I_REQ_ADDR, I_REQ_WDATA, I_EXT_BUS_REQ} = '0;
      I_MUX_ARRANGE = ARR_A24_D8;
      I_BLK_ENABLE = 6'h01;
      I_BLK_BASE = {6{16'h0001}};
      {I_BLK_MASK, I_AUTO_WAIT, I_RECOVERY, I_EXT_WAIT_EN, I_CS_RECOVERY_EN} = '0;
      I_BUS_WIDTH16 = 7'h7F;
      do_reset(1'b1);
      do_reset(1'b0);
      t_basic();
      t_waits();
      t_split();
      t_ext_wait();
      t_grant();
      end_of_test();
   end
endmodule
`default_nettype wire
